// >>> bench/cbs_mem_model.sv
// Far-side memory model: answers bus reads from a fixed address pattern.
// Assumes the sequencer holds a registered address and read strobe for one mclk.
`timescale 1ns/10ps
module cbs_mem_model (
    input  wire logic        mclk,
    input  wire logic [15:0] addr_out,
    input  wire logic        rd_n,
    output logic      [7:0]  data_in
);
    logic [7:0] last_r = 8'h00;
    logic [7:0] pat;

    ////////////////////////////////////////////////////////////////////////
    // Pattern mixes both address bytes
    assign pat     = addr_out[7:0] + addr_out[15:8] + 8'h3C;
    // Released bus shows the inverse of the last byte, never a held value
    assign data_in = rd_n ? ~last_r : pat;

    always @(posedge mclk) begin
        if (!rd_n) begin
            last_r <= pat;
        end
    end
endmodule // cbs_mem_model

// >>> bench/cbs_sequencer_bench.sv
// Self-checking bench for the bus cycle sequencer, one task per scenario.
// Assumes cbs_pkg and the design files are compiled first.
`timescale 1ns/10ps
module cbs_sequencer_bench;
    import cbs_pkg::*;
    logic        mclk = 1'b0;
    logic        rstn;
    logic        start;
    cbs_class_e  op_class;
    logic [15:0] op_addr;
    logic [15:0] stack_ptr;
    logic [15:0] index_reg;
    logic [7:0]  new_value;
    logic [7:0]  data_in;
    logic [15:0] addr_out;
    logic        rw_out;
    logic        rd_n;
    logic        wr_n;
    logic        opcode_load_n;
    logic [7:0]  data_out;
    logic        data_oe;
    logic [7:0]  rd_data;
    logic        rd_strobe;
    logic        busy;
    logic        done;
    logic [15:0] last_ra;
    logic        prev_rd;
    int          fail_count = 0;
    int          n_compared = 0;

    always #20 mclk = ~mclk;

    cbs_sequencer dut (.mclk(mclk), .rstn(rstn), .start(start), .op_class(op_class), .op_addr(op_addr),
        .stack_ptr(stack_ptr), .index_reg(index_reg), .new_value(new_value), .data_in(data_in),
        .addr_out(addr_out), .rw_out(rw_out), .rd_n(rd_n), .wr_n(wr_n), .opcode_load_n(opcode_load_n),
        .data_out(data_out), .data_oe(data_oe), .rd_data(rd_data), .rd_strobe(rd_strobe), .busy(busy),
        .done(done));
    cbs_mem_model mem (.mclk(mclk), .addr_out(addr_out), .rd_n(rd_n), .data_in(data_in));

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] mdat(input logic [15:0] a);
        return a[7:0] + a[15:8] + 8'h3C;
    endfunction

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One bus cycle: address, strobe levels and write data
    task automatic cyc(input cbs_kind_e k, input logic [15:0] a, input logic [7:0] d);
        logic [3:0] s;
        @(negedge mclk);
        s = (k == K_READ) ? 4'hB : (k == K_WRITE) ? 4'h5 : (k == K_DUMMY) ? 4'hF : 4'hA;
        chk("address", a, addr_out);
        chk("rw rd wr load", {12'h000, s}, {12'h000, rw_out, rd_n, wr_n, opcode_load_n});
        chk("drive enable", {15'h0000, k == K_WRITE}, {15'h0000, data_oe});
        if (k == K_WRITE) chk("write data", {8'h00, d}, {8'h00, data_out});
        chk("read strobe", {15'h0000, prev_rd}, {15'h0000, rd_strobe});
        if (k == K_READ || k == K_FETCH) last_ra = a;
        prev_rd = (k == K_READ || k == K_FETCH);
    endtask

    task automatic kick(input cbs_class_e c, input logic [15:0] pc);
        prev_rd = 1'b0;
        @(posedge mclk);
        start    <= 1'b1;
        op_class <= c;
        op_addr  <= pc;
        @(posedge mclk);
        start    <= 1'b0;
    endtask

    // Cycle after the last bus cycle: done pulse and idle bus
    task automatic fin();
        @(negedge mclk);
        chk("done", 16'h0001, {15'h0000, done});
        chk("busy", 16'h0000, {15'h0000, busy});
        chk("idle address", 16'hFFFF, addr_out);
        chk("read byte", {8'h00, mdat(last_ra)}, {8'h00, rd_data});
        chk("final read strobe", {15'h0000, prev_rd}, {15'h0000, rd_strobe});
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic s_dir_rd();
        kick(CBS_DIR_RD, 16'h2000);
        cyc(K_READ, 16'h2001, 8'h00);
        cyc(K_READ, {8'h00, mdat(16'h2001)}, 8'h00);
        cyc(K_FETCH, 16'h2002, 8'h00);
        fin();
    endtask

    task automatic s_ext_reads();
        logic [15:0] ea;
        ea = {mdat(16'h3101), mdat(16'h3102)};
        for (int i = 0; i < 2; i++) begin
            kick((i == 0) ? CBS_EXT_RD8 : CBS_EXT_LD16, 16'h3100);
            cyc(K_READ, 16'h3101, 8'h00);
            cyc(K_READ, 16'h3102, 8'h00);
            cyc(K_READ, ea, 8'h00);
            if (i == 1) cyc(K_READ, ea + 16'h0001, 8'h00);
            cyc(K_FETCH, 16'h3103, 8'h00);
            fin();
        end
    endtask

    task automatic s_jmp_idx();
        kick(CBS_JMP_IDX, 16'h0500);
        cyc(K_READ, 16'h0501, 8'h00);
        cyc(K_DUMMY, 16'hFFFF, 8'h00);
        cyc(K_FETCH, index_reg + mdat(16'h0501), 8'h00);
        fin();
    endtask

    task automatic s_calls();
        logic [15:0] p;
        logic [15:0] ret;
        logic [15:0] tgt;
        p = 16'h1200;
        for (int i = 0; i < 3; i++) begin
            ret = p + ((i == 2) ? 16'h0003 : 16'h0002);
            tgt = (i == 0) ? {8'h00, mdat(p + 16'h0001)} : (i == 1) ? index_reg + mdat(p + 16'h0001)
                : {mdat(p + 16'h0001), mdat(p + 16'h0002)};
            kick((i == 0) ? CBS_JSR_DIR : (i == 1) ? CBS_JSR_IDX : CBS_JSR_EXT, p);
            cyc(K_READ, p + 16'h0001, 8'h00);
            if (i == 2) cyc(K_READ, p + 16'h0002, 8'h00);
            cyc(K_DUMMY, 16'hFFFF, 8'h00);
            cyc(K_WRITE, stack_ptr, ret[7:0]);
            cyc(K_WRITE, stack_ptr - 16'h0001, ret[15:8]);
            cyc(K_FETCH, tgt, 8'h00);
            fin();
        end
    endtask

    task automatic s_return();
        kick(CBS_RTS, 16'h0700);
        cyc(K_READ, 16'h0701, 8'h00);
        cyc(K_DUMMY, 16'hFFFF, 8'h00);
        cyc(K_READ, stack_ptr + 16'h0001, 8'h00);
        cyc(K_READ, stack_ptr + 16'h0002, 8'h00);
        cyc(K_FETCH, {mdat(stack_ptr + 16'h0001), mdat(stack_ptr + 16'h0002)}, 8'h00);
        fin();
    endtask

    task automatic s_pulls();
        for (int i = 0; i < 2; i++) begin
            kick((i == 0) ? CBS_PUL_ACC : CBS_PUL_IDX, 16'h0800);
            cyc(K_FETCH, 16'h0801, 8'h00);
            cyc(K_DUMMY, 16'hFFFF, 8'h00);
            cyc(K_READ, stack_ptr + 16'h0001, 8'h00);
            if (i == 1) cyc(K_READ, stack_ptr + 16'h0002, 8'h00);
            fin();
        end
    endtask

    // Multiply with a start given mid-run, which must be ignored
    task automatic s_prefetch();
        kick(CBS_MUL, 16'h0900);
        cyc(K_FETCH, 16'h0901, 8'h00);
        @(posedge mclk);
        start <= 1'b1;
        cyc(K_DUMMY, 16'hFFFF, 8'h00);
        @(posedge mclk);
        start <= 1'b0;
        for (int i = 0; i < 5; i++) cyc(K_DUMMY, 16'hFFFF, 8'h00);
        fin();
        @(negedge mclk);
        chk("busy after refused start", 16'h0000, {15'h0000, busy});
        kick(CBS_ADJ_SWAP, 16'h0A00);
        cyc(K_FETCH, 16'h0A01, 8'h00);
        cyc(K_DUMMY, 16'hFFFF, 8'h00);
        fin();
    endtask

    task automatic s_mask();
        logic [15:0] ea;
        for (int i = 0; i < 2; i++) begin
            ea = (i == 0) ? {8'h00, mdat(16'h0B02)} : index_reg + mdat(16'h0B02);
            kick((i == 0) ? CBS_AIM_DIR : CBS_AIM_IDX, 16'h0B00);
            cyc(K_READ, 16'h0B01, 8'h00);
            cyc(K_READ, 16'h0B02, 8'h00);
            if (i == 1) cyc(K_DUMMY, 16'hFFFF, 8'h00);
            cyc(K_READ, ea, 8'h00);
            cyc(K_DUMMY, 16'hFFFF, 8'h00);
            cyc(K_WRITE, ea, new_value);
            cyc(K_FETCH, 16'h0B03, 8'h00);
            fin();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        rstn      = 1'b0;
        start     = 1'b0;
        op_class  = CBS_DIR_RD;
        op_addr   = 16'h0000;
        stack_ptr = 16'h01F0;
        index_reg = 16'h4400;
        new_value = 8'h6C;
        last_ra   = 16'h0000;
        prev_rd   = 1'b0;
        repeat (5) @(posedge mclk);
        chk("reset address", 16'hFFFF, addr_out);
        chk("reset busy", 16'h0000, {15'h0000, busy});
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        s_dir_rd();
        s_ext_reads();
        s_jmp_idx();
        s_calls();
        s_return();
        s_pulls();
        s_prefetch();
        s_mask();
        end_sim();
    end
endmodule // cbs_sequencer_bench

// >>> rtl/cbs_consts.svh
// Constants of the bus cycle sequencer: addresses, counts, lengths.
// Assumes inclusion by bare name from the package; the sequencer uses its macros without including it.
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH
`define CBS_DUMMY_ADDR   16'hFFFF
`define CBS_ZERO_HI      8'h00
`define CBS_LEN_TWO      16'h0002
`define CBS_LEN_THREE    16'h0003
`define CBS_ONE16        16'h0001
`define CBS_N_DIR_RD     3'h3
`define CBS_N_EXT_RD8    3'h4
`define CBS_N_EXT_LD16   3'h5
`define CBS_N_JMP_IDX    3'h3
`define CBS_N_JSR_DIR    3'h5
`define CBS_N_JSR_IDX    3'h5
`define CBS_N_JSR_EXT    3'h6
`define CBS_N_RTS        3'h5
`define CBS_N_PUL_ACC    3'h3
`define CBS_N_PUL_IDX    3'h4
`define CBS_N_MUL        3'h7
`define CBS_N_ADJ_SWAP   3'h2
`define CBS_N_AIM_DIR    3'h6
`define CBS_N_AIM_IDX    3'h7
`endif

// >>> rtl/cbs_pkg.sv
// Types of the bus cycle sequencer.
// Assumes cbs_consts.svh sits beside it.
package cbs_pkg;
`include "cbs_consts.svh"

    typedef enum logic [3:0] {
        CBS_DIR_RD, CBS_EXT_RD8, CBS_EXT_LD16, CBS_JMP_IDX, CBS_JSR_DIR, CBS_JSR_IDX,
        CBS_JSR_EXT, CBS_RTS, CBS_PUL_ACC, CBS_PUL_IDX, CBS_MUL, CBS_ADJ_SWAP,
        CBS_AIM_DIR, CBS_AIM_IDX
    } cbs_class_e;

    typedef enum logic [1:0] {K_READ, K_WRITE, K_DUMMY, K_FETCH} cbs_kind_e;
    typedef enum logic [3:0] {
        A_PC1, A_PC2, A_PCLEN, A_EA, A_EA1, A_SP, A_SPM1, A_SPP1, A_SPP2, A_FFFF
    } cbs_asrc_e;
    typedef enum logic [2:0] {C_NONE, C_DIR, C_HI, C_LO, C_OFF} cbs_cap_e;
    typedef enum logic [1:0] {D_NONE, D_RET_LO, D_RET_HI, D_NEWVAL} cbs_dsrc_e;

    typedef struct packed {
        cbs_kind_e kind;
        cbs_asrc_e asrc;
        cbs_cap_e  cap;
        cbs_dsrc_e dsrc;
        logic      last;
    } cbs_step_s;

    typedef enum logic [1:0] {S_IDLE = 2'b01, S_RUN = 2'b10} cbs_state_e;
endpackage

// >>> rtl/cbs_sequencer.sv
// Bus cycle sequencer: walks one instruction's bus cycles, one per mclk.
// Assumes the core presents class and register copies with start while idle.
`timescale 1ns/10ps
module cbs_sequencer
    import cbs_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic        start,
    input  cbs_pkg::cbs_class_e op_class,
    input  wire logic [15:0] op_addr,
    input  wire logic [15:0] stack_ptr,
    input  wire logic [15:0] index_reg,
    input  wire logic [7:0]  new_value,
    input  wire logic [7:0]  data_in,
    output logic [15:0]      addr_out,
    output logic             rw_out,
    output logic             rd_n,
    output logic             wr_n,
    output logic             opcode_load_n,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic [7:0]       rd_data,
    output logic             rd_strobe,
    output logic             busy,
    output logic             done
);
    import cbs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_a_r, rst_n_s;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_a_r <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_n_s <= rst_a_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State and table lookup
    cbs_state_e state_r, state_nxt;
    cbs_class_e cls_r;
    cbs_class_e cls_nxt;
    logic [2:0] idx_r;
    logic [15:0] pc_r, sp_r, ix_r, ea_r, ea_nxt;
    cbs_step_s cur_step;
    cbs_step_if stp ();

    wire idle     = (state_r == S_IDLE);
    wire take     = idle && start;
    wire finish   = !idle && cur_step.last;
    wire advance  = !idle && !cur_step.last;
    wire [2:0] idx_nxt = take ? 3'h1 : (idx_r + 3'h1);
    wire [15:0] pc_use = take ? op_addr : pc_r;
    wire [15:0] sp_use = take ? stack_ptr : sp_r;
    wire [15:0] ix_use = take ? index_reg : ix_r;
    wire [15:0] len    = (cls_nxt == CBS_JSR_EXT || cls_nxt == CBS_EXT_RD8 || cls_nxt == CBS_EXT_LD16 ||
                          cls_nxt == CBS_AIM_DIR || cls_nxt == CBS_AIM_IDX) ? `CBS_LEN_THREE : `CBS_LEN_TWO;
    wire [15:0] ret_addr = pc_use + len;
    assign cls_nxt = take ? op_class : cls_r;

    assign stp.cls = cls_nxt;
    assign stp.idx = idx_nxt;
    cbs_step_table u_table (.tbl(stp));

    // Cycle now on the bus, kept for capture at its end
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cur_step <= '{kind: K_DUMMY, asrc: A_FFFF, cap: C_NONE, dsrc: D_NONE, last: 1'b0};
        end else if (take || advance) begin
            cur_step <= stp.step;
        end
    end

    // Address capture from the byte read in the cycle now on the bus, at its end
    always_comb begin
        ea_nxt = ea_r;
        if (!idle) begin
            case (cur_step.cap)
                C_DIR:   ea_nxt = {`CBS_ZERO_HI, data_in};
                C_HI:    ea_nxt = {data_in, ea_r[7:0]};
                C_LO:    ea_nxt = {ea_r[15:8], data_in};
                C_OFF:   ea_nxt = ix_r + {`CBS_ZERO_HI, data_in};
                default: ea_nxt = ea_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address and strobe decode for the cycle being entered
    cbs_step_s nx;
    assign nx = stp.step;
    wire [15:0] addr_nxt =
        (nx.asrc == A_PC1)   ? pc_use + `CBS_ONE16 :
        (nx.asrc == A_PC2)   ? pc_use + `CBS_LEN_TWO :
        (nx.asrc == A_PCLEN) ? ret_addr :
        (nx.asrc == A_EA)    ? ea_nxt :
        (nx.asrc == A_EA1)   ? ea_nxt + `CBS_ONE16 :
        (nx.asrc == A_SP)    ? sp_use :
        (nx.asrc == A_SPM1)  ? sp_use - `CBS_ONE16 :
        (nx.asrc == A_SPP1)  ? sp_use + `CBS_ONE16 :
        (nx.asrc == A_SPP2)  ? sp_use + `CBS_LEN_TWO :
        `CBS_DUMMY_ADDR;
    wire is_rd = (nx.kind == K_READ) || (nx.kind == K_FETCH);
    wire is_wr = (nx.kind == K_WRITE);
    wire [7:0] dout_nxt = (nx.dsrc == D_RET_LO) ? ret_addr[7:0] :
                          (nx.dsrc == D_RET_HI) ? ret_addr[15:8] : new_value;
    wire load = take || advance;

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_r <= S_IDLE;
            cls_r   <= CBS_MUL;
            idx_r   <= 3'h0;
            pc_r    <= 16'h0000;
            sp_r    <= 16'h0000;
            ix_r    <= 16'h0000;
            ea_r    <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cls_r   <= cls_nxt;
            pc_r    <= pc_use;
            sp_r    <= sp_use;
            ix_r    <= ix_use;
            ea_r    <= take ? 16'h0000 : ea_nxt;
            if (load) begin
                idx_r <= idx_nxt;
            end
        end
    end

    always_comb begin
        case (state_r)
            S_IDLE:  state_nxt = start ? S_RUN : S_IDLE;
            S_RUN:   state_nxt = cur_step.last ? S_IDLE : S_RUN;
            default: state_nxt = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus outputs, registered
    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            addr_out      <= `CBS_DUMMY_ADDR;
            rw_out        <= 1'b1;
            rd_n          <= 1'b1;
            wr_n          <= 1'b1;
            opcode_load_n <= 1'b1;
            data_out      <= 8'h00;
            data_oe       <= 1'b0;
        end else if (load) begin
            addr_out      <= addr_nxt;
            rw_out        <= !is_wr;
            rd_n          <= !is_rd;
            wr_n          <= !is_wr;
            opcode_load_n <= (nx.kind != K_FETCH);
            data_out      <= is_wr ? dout_nxt : 8'h00;
            data_oe       <= is_wr;
        end else begin
            addr_out      <= `CBS_DUMMY_ADDR;
            rw_out        <= 1'b1;
            rd_n          <= 1'b1;
            wr_n          <= 1'b1;
            opcode_load_n <= 1'b1;
            data_oe       <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            rd_data   <= 8'h00;
            rd_strobe <= 1'b0;
            done      <= 1'b0;
        end else begin
            rd_strobe <= !idle && (cur_step.kind == K_READ || cur_step.kind == K_FETCH);
            if (!idle && (cur_step.kind == K_READ || cur_step.kind == K_FETCH)) begin
                rd_data <= data_in;
            end
            done <= finish;
        end
    end

    assign busy = !idle;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    read_strobes_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        !rd_n |-> rw_out && wr_n && !data_oe)
        else $error("read cycle strobes wrong");
    write_strobes_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        !wr_n |-> !rw_out && rd_n && data_oe)
        else $error("write cycle strobes wrong");
    prefetch_first_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_MUL |=> !opcode_load_n && addr_out == pc_r + 16'h0001)
        else $error("multiply did not prefetch in cycle one");
    mul_length_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_MUL |=> busy [*7] ##1 !busy)
        else $error("multiply cycle count wrong");
    jump_idx_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_JMP_IDX |=> !rd_n ##1 (addr_out == 16'hFFFF && rd_n && wr_n)
        ##1 (!opcode_load_n && addr_out == ea_r))
        else $error("indexed jump sequence wrong");
    call_ext_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_JSR_EXT |=> ##3 (!wr_n && addr_out == sp_r &&
        data_out == 8'(pc_r + 16'h0003)) ##1 (!wr_n && addr_out == sp_r - 16'h0001) ##1 !opcode_load_n)
        else $error("extended call sequence wrong");
    return_seq_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_RTS |=> ##2 addr_out == sp_r + 16'h0001 ##1 addr_out == sp_r + 16'h0002
        ##1 (!opcode_load_n && addr_out == ea_r))
        else $error("return sequence wrong");
    pull_index_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_PUL_IDX |=> !opcode_load_n ##1 addr_out == 16'hFFFF
        ##1 addr_out == sp_r + 16'h0001 ##1 addr_out == sp_r + 16'h0002 ##1 !busy)
        else $error("index pull sequence wrong");
    direct_read_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_DIR_RD |=> ##2 (!opcode_load_n && addr_out == pc_r + 16'h0002))
        else $error("direct read fetch address wrong");
    ext_load_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_EXT_LD16 |=> ##3 addr_out == ea_r + 16'h0001
        ##1 (!opcode_load_n && addr_out == pc_r + 16'h0003))
        else $error("extended load sequence wrong");
    rmw_back_a: assert property (@(posedge mclk) disable iff (!rst_n_s)
        take && op_class == CBS_AIM_DIR |=> ##3 addr_out == 16'hFFFF
        ##1 (!wr_n && addr_out == $past(addr_out, 2)))
        else $error("read-modify-write did not write back");
endmodule // cbs_sequencer

// >>> rtl/cbs_step_if.sv
// Carrier between the sequencer and its cycle table.
// Assumes cbs_pkg is compiled first.
`timescale 1ns/10ps
interface cbs_step_if;
    import cbs_pkg::*;
    cbs_class_e cls;
    logic [2:0] idx;
    cbs_step_s  step;
    modport table_side (input cls, input idx, output step);
    modport seq_side   (output cls, output idx, input step);
endinterface

// >>> rtl/cbs_step_table.sv
// Cycle table: for an instruction class and cycle number, what the bus does.
// Assumes cycle numbers start at 1 and stay within the class count.
`timescale 1ns/10ps
module cbs_step_table
    import cbs_pkg::*;
(
    cbs_step_if.table_side tbl
);
    function automatic cbs_step_s mk(cbs_kind_e k, cbs_asrc_e a, cbs_cap_e c, cbs_dsrc_e d);
        cbs_step_s s;
        s.kind = k;
        s.asrc = a;
        s.cap  = c;
        s.dsrc = d;
        s.last = 1'b0;
        return s;
    endfunction

    cbs_step_s  row;
    logic [2:0] count;

    always_comb begin
        row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
        count = 3'h1;
        case (tbl.cls)
            CBS_DIR_RD: begin
                count = `CBS_N_DIR_RD;
                case (tbl.idx)
                    3'h1: row = mk(K_READ, A_PC1, C_DIR, D_NONE);
                    3'h2: row = mk(K_READ, A_EA, C_NONE, D_NONE);
                    default: row = mk(K_FETCH, A_PCLEN, C_NONE, D_NONE);
                endcase
            end
            CBS_EXT_RD8, CBS_EXT_LD16: begin
                count = (tbl.cls == CBS_EXT_RD8) ? `CBS_N_EXT_RD8 : `CBS_N_EXT_LD16;
                case (tbl.idx)
                    3'h1: row = mk(K_READ, A_PC1, C_HI, D_NONE);
                    3'h2: row = mk(K_READ, A_PC2, C_LO, D_NONE);
                    3'h3: row = mk(K_READ, A_EA, C_NONE, D_NONE);
                    3'h4: row = (tbl.cls == CBS_EXT_LD16) ? mk(K_READ, A_EA1, C_NONE, D_NONE)
                                                          : mk(K_FETCH, A_PCLEN, C_NONE, D_NONE);
                    default: row = mk(K_FETCH, A_PCLEN, C_NONE, D_NONE);
                endcase
            end
            CBS_JMP_IDX: begin
                count = `CBS_N_JMP_IDX;
                case (tbl.idx)
                    3'h1: row = mk(K_READ, A_PC1, C_OFF, D_NONE);
                    3'h2: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    default: row = mk(K_FETCH, A_EA, C_NONE, D_NONE);
                endcase
            end
            CBS_JSR_DIR, CBS_JSR_IDX, CBS_JSR_EXT: begin
                count = (tbl.cls == CBS_JSR_EXT) ? `CBS_N_JSR_EXT
                      : (tbl.cls == CBS_JSR_DIR) ? `CBS_N_JSR_DIR : `CBS_N_JSR_IDX;
                case (tbl.idx + ((tbl.cls == CBS_JSR_EXT) ? 3'h0 : 3'h1))
                    3'h1: row = mk(K_READ, A_PC1, C_HI, D_NONE);
                    3'h2: row = (tbl.cls == CBS_JSR_EXT) ? mk(K_READ, A_PC2, C_LO, D_NONE)
                              : mk(K_READ, A_PC1, (tbl.cls == CBS_JSR_DIR) ? C_DIR : C_OFF, D_NONE);
                    3'h3: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    3'h4: row = mk(K_WRITE, A_SP, C_NONE, D_RET_LO);
                    3'h5: row = mk(K_WRITE, A_SPM1, C_NONE, D_RET_HI);
                    default: row = mk(K_FETCH, A_EA, C_NONE, D_NONE);
                endcase
            end
            CBS_RTS: begin
                count = `CBS_N_RTS;
                case (tbl.idx)
                    3'h1: row = mk(K_READ, A_PC1, C_NONE, D_NONE);
                    3'h2: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    3'h3: row = mk(K_READ, A_SPP1, C_HI, D_NONE);
                    3'h4: row = mk(K_READ, A_SPP2, C_LO, D_NONE);
                    default: row = mk(K_FETCH, A_EA, C_NONE, D_NONE);
                endcase
            end
            CBS_PUL_ACC, CBS_PUL_IDX, CBS_MUL, CBS_ADJ_SWAP: begin
                count = (tbl.cls == CBS_PUL_ACC) ? `CBS_N_PUL_ACC
                      : (tbl.cls == CBS_PUL_IDX) ? `CBS_N_PUL_IDX
                      : (tbl.cls == CBS_MUL) ? `CBS_N_MUL : `CBS_N_ADJ_SWAP;
                case (tbl.idx)
                    3'h1: row = mk(K_FETCH, A_PC1, C_NONE, D_NONE);
                    3'h3: row = (tbl.cls == CBS_PUL_ACC || tbl.cls == CBS_PUL_IDX)
                              ? mk(K_READ, A_SPP1, C_NONE, D_NONE) : mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    3'h4: row = (tbl.cls == CBS_PUL_IDX)
                              ? mk(K_READ, A_SPP2, C_NONE, D_NONE) : mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    default: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                endcase
            end
            CBS_AIM_DIR, CBS_AIM_IDX: begin
                count = (tbl.cls == CBS_AIM_DIR) ? `CBS_N_AIM_DIR : `CBS_N_AIM_IDX;
                // Direct form skips the indexed form's dummy in cycle 3
                case (tbl.idx + ((tbl.cls == CBS_AIM_DIR && tbl.idx >= 3'h3) ? 3'h1 : 3'h0))
                    3'h1: row = mk(K_READ, A_PC1, C_NONE, D_NONE);
                    3'h2: row = mk(K_READ, A_PC2, (tbl.cls == CBS_AIM_DIR) ? C_DIR : C_OFF, D_NONE);
                    3'h3: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    3'h4: row = mk(K_READ, A_EA, C_NONE, D_NONE);
                    3'h5: row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
                    3'h6: row = mk(K_WRITE, A_EA, C_NONE, D_NEWVAL);
                    default: row = mk(K_FETCH, A_PCLEN, C_NONE, D_NONE);
                endcase
            end
            default: begin
                count = 3'h1;
                row = mk(K_DUMMY, A_FFFF, C_NONE, D_NONE);
            end
        endcase
    end

    assign tbl.step = '{kind: row.kind, asrc: row.asrc, cap: row.cap, dsrc: row.dsrc,
                        last: (tbl.idx == count)};
endmodule // cbs_step_table
